//--- rtl/pvl_voter.sv
/*
 pvl_voter: two-of-four protective voting, trip latch, setpoint
 enforcement, bypass removal, second-highest control selection,
 deviation alarms and rod block / runback demands, with a classic
 Wishbone register slave. Assumes channel words and switch levels
 arrive asynchronously and are resynchronised here.
*/
`timescale 1ns/10ps
module pvl_voter
   import pvl_pkg::*;
(
   // clock and reset
   input  wire logic                      clk_i,
   input  wire logic                      rst_i,
   // wishbone slave
   input  wire logic                      cyc_i,
   input  wire logic                      stb_i,
   input  wire logic                      we_i,
   input  wire logic [7:0]                adr_i,
   input  wire logic [3:0]                sel_i,
   input  wire logic [31:0]               dat_i,
   output      logic [31:0]               dat_o,
   output      logic                      ack_o,
   // channel values
   input  wire logic [NCH-1:0][VAL_W-1:0] flux_i,
   input  wire logic [NCH-1:0][VAL_W-1:0] tavg_i,
   input  wire logic [NCH-1:0][VAL_W-1:0] dt_i,
   // switches
   input  wire logic                      permissive_i,
   input  wire logic                      manual_trip_i,
   input  wire logic                      op_reset_i,
   // protective and alarm outputs
   output      logic                      reactor_trip_o,
   output      logic                      trip_alarm_o,
   output      logic                      trip_annunc_o,
   output      logic [NCH-1:0]            first_cause_o,
   output      logic                      visual_alarm_o,
   output      logic                      audible_alarm_o,
   output      logic                      rod_block_man_o,
   output      logic                      rod_block_auto_o,
   output      logic                      turbine_runback_o,
   output      logic                      flux_dev_alarm_o,
   output      logic                      temp_dev_alarm_o,
   output      logic                      bypass_ind_o,
   // control values
   output      logic [VAL_W-1:0]          flux_ctl_o,
   output      logic [VAL_W-1:0]          tavg_ctl_o
);

////////////////////////////////////////////////////////////////////////
   typedef logic [NCH-1:0][VAL_W-1:0] pvl_vec_t;

   typedef struct packed {
      pvl_vec_t          s1_flux;
      pvl_vec_t          s2_flux;
      pvl_vec_t          s1_tavg;
      pvl_vec_t          s2_tavg;
      pvl_vec_t          s1_dt;
      pvl_vec_t          s2_dt;
      logic [2:0]        s1_sw;
      logic [2:0]        s2_sw;
      logic              tight;
      logic [NCH-1:0]    bypass;
      logic [NCH-1:0]    test;
      logic [VAL_W-1:0]  flx_hi;
      logic [VAL_W-1:0]  flx_lo;
      logic [VAL_W-1:0]  rod_sp;
      logic [VAL_W-1:0]  fdev_sp;
      logic [VAL_W-1:0]  tdev_sp;
      logic [VAL_W-1:0]  dt_pct;
      pvl_vec_t          dt_nom;
      logic              trip;
      logic [NCH-1:0]    cause;
      logic              ch_alarm;
      logic              rod_stop;
      logic              dt_vote;
      logic              fdev;
      logic              tdev;
      logic [VAL_W-1:0]  flux_ctl;
      logic [VAL_W-1:0]  tavg_ctl;
      logic              ack;
      logic [31:0]       rdat;
   } pvl_state_t;

   pvl_state_t st_r;
   pvl_state_t st_nxt;

////////////////////////////////////////////////////////////////////////
   // helpers
   function automatic logic [VAL_W-1:0] mx(input logic [VAL_W-1:0] a,
                                           input logic [VAL_W-1:0] b);
      mx = (a > b) ? a : b;
   endfunction : mx

   function automatic logic [VAL_W-1:0] mn(input logic [VAL_W-1:0] a,
                                           input logic [VAL_W-1:0] b);
      mn = (a < b) ? a : b;
   endfunction : mn

   // second highest of four without a full sort
   function automatic logic [VAL_W-1:0] sec_high(input pvl_vec_t v);
      sec_high = mx(mn(mx(v[0], v[1]), mx(v[2], v[3])),
                    mx(mn(v[0], v[1]), mn(v[2], v[3])));
   endfunction : sec_high

   function automatic logic [VAL_W-1:0] adiff(input logic [VAL_W-1:0] a,
                                              input logic [VAL_W-1:0] b);
      adiff = (a > b) ? a - b : b - a;
   endfunction : adiff

   function automatic logic two_of(input logic [NCH-1:0] f);
      logic [2:0] c;
      c = 3'h0;
      for (int i = 0; i < NCH; i++) begin
         c = c + {2'h0, f[i]};
      end
      two_of = (c >= 3'h2);
   endfunction : two_of

   // byte-lane merge of a 16-bit register
   function automatic logic [VAL_W-1:0] bmerge(input logic [VAL_W-1:0] o,
                                               input logic [31:0] d,
                                               input logic [3:0] s);
      bmerge[7:0]  = s[0] ? d[7:0] : o[7:0];
      bmerge[15:8] = s[1] ? d[15:8] : o[15:8];
   endfunction : bmerge

////////////////////////////////////////////////////////////////////////
   // combinational view used by the next-state logic and assertions
   logic            perm_s;
   logic            man_s;
   logic            opr_s;
   logic [VAL_W-1:0] trip_sp;
   logic [VAL_W-1:0] stop_sp;
   logic [NCH-1:0]  op_raw;
   logic [NCH-1:0]  op_eff;
   logic [NCH-1:0]  rod_flag;
   logic [NCH-1:0]  dt_flag;
   logic            auto_vote;
   logic            wb_req;
   logic            wb_wr;

   assign perm_s = st_r.s2_sw[0];
   assign man_s  = st_r.s2_sw[1];
   assign opr_s  = st_r.s2_sw[2];
   // tight mode can only lower the setpoint, never raise it
   assign trip_sp = st_r.tight ? mn(st_r.flx_lo, st_r.flx_hi) : st_r.flx_hi;
   // rod stop clamped under the active trip setpoint
   assign stop_sp = (st_r.rod_sp < trip_sp) ? st_r.rod_sp :
                    ((trip_sp == 16'h0000) ? 16'h0000 : trip_sp - 16'h0001);
   assign wb_req = cyc_i & stb_i;
   assign wb_wr  = wb_req & we_i & st_r.ack;

   // per-channel bistables from the synchronised values
   always_comb begin
      for (int i = 0; i < NCH; i++) begin
         op_raw[i]   = st_r.s2_flux[i] >= trip_sp;
         // bypass masks a flag, test forces it tripped
         op_eff[i]   = st_r.test[i] | (op_raw[i] & ~st_r.bypass[i]);
         rod_flag[i] = st_r.s2_flux[i] >= stop_sp;
         // scaled compare keeps each loop relative to its own nominal
         dt_flag[i]  = ({16'h0000, st_r.s2_dt[i]} * PCT_FULL) >=
                       ({16'h0000, st_r.dt_nom[i]} * {16'h0000, st_r.dt_pct});
      end
   end

   // vote works on flags only, never on the selected control value
   assign auto_vote = two_of(op_eff);

////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      logic [VAL_W-1:0] fsel;
      logic [VAL_W-1:0] tsel;
      logic             fd;
      logic             td;
      logic             set_trip;
      st_nxt   = st_r;
      fsel     = sec_high(st_r.s2_flux);
      tsel     = sec_high(st_r.s2_tavg);
      fd       = 1'b0;
      td       = 1'b0;
      set_trip = auto_vote | man_s;
      // two-stage synchronisers on every channel word and switch input; bus inputs are used directly
      st_nxt.s1_flux = flux_i;
      st_nxt.s2_flux = st_r.s1_flux;
      st_nxt.s1_tavg = tavg_i;
      st_nxt.s2_tavg = st_r.s1_tavg;
      st_nxt.s1_dt   = dt_i;
      st_nxt.s2_dt   = st_r.s1_dt;
      st_nxt.s1_sw   = {op_reset_i, manual_trip_i, permissive_i};
      st_nxt.s2_sw   = st_r.s1_sw;
      // deviation from the selected reference
      for (int i = 0; i < NCH; i++) begin
         fd = fd | (adiff(st_r.s2_flux[i], fsel) > st_r.fdev_sp);
         td = td | (adiff(st_r.s2_tavg[i], tsel) > st_r.tdev_sp);
      end
      st_nxt.flux_ctl = fsel;
      st_nxt.tavg_ctl = tsel;
      st_nxt.fdev     = fd;
      st_nxt.tdev     = td;
      st_nxt.rod_stop = |rod_flag;
      st_nxt.ch_alarm = |op_raw | |st_r.test;
      st_nxt.dt_vote  = two_of(dt_flag);
      // latch: new demand wins over a simultaneous operator reset
      st_nxt.trip = (st_r.trip & ~opr_s) | set_trip;
      if (opr_s & ~set_trip) begin
         st_nxt.cause = '0;
      end
      if (auto_vote & ~(st_r.trip & ~opr_s)) begin
         st_nxt.cause = op_eff;
      end
      // wishbone: ack one cycle after the request, then drop
      st_nxt.ack = wb_req & ~st_r.ack;
      if (wb_req & ~st_r.ack) begin
         st_nxt.rdat = 32'h0000_0000;
         if (adr_i == ADR_CTRL) begin
            st_nxt.rdat[0] = st_r.tight;
         end else if (adr_i == ADR_BYP) begin
            st_nxt.rdat[NCH-1:0] = st_r.bypass;
         end else if (adr_i == ADR_TEST) begin
            st_nxt.rdat[NCH-1:0] = st_r.test;
         end else if (adr_i == ADR_FLX_HI) begin
            st_nxt.rdat[VAL_W-1:0] = st_r.flx_hi;
         end else if (adr_i == ADR_FLX_LO) begin
            st_nxt.rdat[VAL_W-1:0] = st_r.flx_lo;
         end else if (adr_i == ADR_ROD) begin
            st_nxt.rdat[VAL_W-1:0] = st_r.rod_sp;
         end else if (adr_i == ADR_FDEV) begin
            st_nxt.rdat[VAL_W-1:0] = st_r.fdev_sp;
         end else if (adr_i == ADR_TDEV) begin
            st_nxt.rdat[VAL_W-1:0] = st_r.tdev_sp;
         end else if (adr_i == ADR_DTPCT) begin
            st_nxt.rdat[VAL_W-1:0] = st_r.dt_pct;
         end else if (adr_i == ADR_STAT) begin
            st_nxt.rdat[ST_TRIP] = st_r.trip | man_s;
            st_nxt.rdat[ST_RODB] = st_r.rod_stop | st_r.dt_vote;
            st_nxt.rdat[ST_RUNB] = st_r.dt_vote;
            st_nxt.rdat[ST_FDEV] = st_r.fdev;
            st_nxt.rdat[ST_TDEV] = st_r.tdev;
            st_nxt.rdat[ST_BYPI] = |st_r.bypass | |st_r.test;
            st_nxt.rdat[ST_CAUSE +: NCH] = st_r.cause;
            st_nxt.rdat[ST_BYPA +: NCH]  = st_r.bypass;
         end else if (adr_i == ADR_FSEL) begin
            st_nxt.rdat[VAL_W-1:0] = st_r.flux_ctl;
         end else if (adr_i == ADR_TSEL) begin
            st_nxt.rdat[VAL_W-1:0] = st_r.tavg_ctl;
         end else if ((adr_i & ADR_NOM_MASK) == ADR_DTNOM) begin
            st_nxt.rdat[VAL_W-1:0] = st_r.dt_nom[adr_i[3:2]];
         end
      end
      // writes take effect on the edge where ack is seen
      if (wb_wr) begin
         if (adr_i == ADR_CTRL) begin
            st_nxt.tight = sel_i[0] ? dat_i[0] : st_r.tight;
         end else if (adr_i == ADR_BYP) begin
            st_nxt.bypass = sel_i[0] ? dat_i[NCH-1:0] : st_r.bypass;
         end else if (adr_i == ADR_TEST) begin
            st_nxt.test = sel_i[0] ? dat_i[NCH-1:0] : st_r.test;
         end else if (adr_i == ADR_FLX_HI) begin
            st_nxt.flx_hi = bmerge(st_r.flx_hi, dat_i, sel_i);
         end else if (adr_i == ADR_FLX_LO) begin
            st_nxt.flx_lo = bmerge(st_r.flx_lo, dat_i, sel_i);
         end else if (adr_i == ADR_ROD) begin
            st_nxt.rod_sp = bmerge(st_r.rod_sp, dat_i, sel_i);
         end else if (adr_i == ADR_FDEV) begin
            st_nxt.fdev_sp = bmerge(st_r.fdev_sp, dat_i, sel_i);
         end else if (adr_i == ADR_TDEV) begin
            st_nxt.tdev_sp = bmerge(st_r.tdev_sp, dat_i, sel_i);
         end else if (adr_i == ADR_DTPCT) begin
            st_nxt.dt_pct = bmerge(st_r.dt_pct, dat_i, sel_i);
         end else if ((adr_i & ADR_NOM_MASK) == ADR_DTNOM) begin
            st_nxt.dt_nom[adr_i[3:2]] = bmerge(st_r.dt_nom[adr_i[3:2]], dat_i, sel_i);
         end
      end
      // removal beats any write: no bypass survives a lost permissive
      st_nxt.bypass = st_nxt.bypass & {NCH{perm_s}};
   end

////////////////////////////////////////////////////////////////////////
   // state register, synchronous reset to the inactive state
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_r         <= '0;
         st_r.flx_hi  <= RST_FLX_HI;
         st_r.flx_lo  <= RST_FLX_LO;
         st_r.rod_sp  <= RST_ROD;
         st_r.fdev_sp <= RST_DEV;
         st_r.tdev_sp <= RST_DEV;
         st_r.dt_pct  <= RST_DTPCT;
         st_r.dt_nom  <= {NCH{RST_DTNOM}};
      end else begin
         st_r <= st_nxt;
      end
   end

////////////////////////////////////////////////////////////////////////
   // outputs; manual path reaches the trip without the vote
   assign reactor_trip_o    = st_r.trip | man_s;
   assign trip_alarm_o      = reactor_trip_o;
   assign trip_annunc_o     = reactor_trip_o;
   assign first_cause_o     = st_r.cause;
   assign visual_alarm_o    = st_r.ch_alarm | st_r.rod_stop;
   assign audible_alarm_o   = st_r.ch_alarm | st_r.rod_stop;
   assign rod_block_man_o   = st_r.rod_stop;
   assign rod_block_auto_o  = st_r.rod_stop | st_r.dt_vote;
   assign turbine_runback_o = st_r.dt_vote;
   assign flux_dev_alarm_o  = st_r.fdev;
   assign temp_dev_alarm_o  = st_r.tdev;
   assign bypass_ind_o      = |st_r.bypass | |st_r.test;
   assign flux_ctl_o        = st_r.flux_ctl;
   assign tavg_ctl_o        = st_r.tavg_ctl;
   assign dat_o             = st_r.rdat;
   assign ack_o             = st_r.ack;

////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence s_req_new;
      wb_req && !ack_o;
   endsequence
   sequence s_ack_pulse;
      ack_o ##1 !ack_o;
   endsequence

   bus_ack_a: assert property (s_req_new |=> s_ack_pulse)
      else $error("ack not a single cycle pulse");
   byp_clear_a: assert property (!perm_s |=> bypass_ind_o == |st_r.test)
      else $error("bypass kept without permissive");
   byp_ind_a: assert property ($rose(|st_r.bypass) |-> bypass_ind_o)
      else $error("bypass not indicated");
   tight_sp_a: assert property (st_r.tight |-> trip_sp <= st_r.flx_lo)
      else $error("loose setpoint used in tight mode");
   trip_hold_a: assert property (reactor_trip_o && !opr_s |=> reactor_trip_o)
      else $error("trip released without operator reset");
   trip_rel_a: assert property ($fell(st_r.trip) |-> $past(opr_s))
      else $error("trip latch fell without reset");
   man_path_a: assert property (man_s |-> reactor_trip_o ##1 st_r.trip)
      else $error("manual trip not effective");
   trip_alarm_a: assert property (reactor_trip_o |-> trip_alarm_o && trip_annunc_o)
      else $error("trip without alarm");
   cause_set_a: assert property ($rose(st_r.trip) && $past(auto_vote) |->
                                 first_cause_o == $past(op_eff))
      else $error("first cause wrong");
   vote_trip_a: assert property (auto_vote |=> st_r.trip ##1 (st_r.trip || $past(opr_s)))
      else $error("2 of 4 vote did not trip");
   rod_block_a: assert property (|rod_flag |=> rod_block_man_o && rod_block_auto_o)
      else $error("rod stop without withdrawal block");
   stop_below_a: assert property (trip_sp != 16'h0000 |-> stop_sp < trip_sp)
      else $error("rod stop not below trip");
   runback_a: assert property (two_of(dt_flag) |=> turbine_runback_o && rod_block_auto_o)
      else $error("dT vote without runback");
   alarm_any_a: assert property (|op_raw |=> visual_alarm_o && audible_alarm_o)
      else $error("channel trip without alarm");

endmodule : pvl_voter

//--- rtl/pvl_pkg.sv
/*
 pvl_pkg: constants, register map and field layout for the protection
 voting block. Assumes a 32-bit classic Wishbone slave port and four
 redundant measurement channels of 16-bit unsigned values.
*/
// Functional notes
// - bypass drops itself when permissive goes false
// - indicate any bypassed or tested channel
// - tight mode forces lower flux trip setpoint
// - protective action stays latched once set
// - only operator reset releases the latch
// - manual trip bypasses automatic voting path
// - reactor trip raises alarm and annunciator
// - per-channel first cause of each voted trip; a manual trip leaves it at zero
// - rod stop or channel trip alarms both
// - rod control flux is second highest channel
// - overpower trip on two of four flags
// - flux deviation alarm above set threshold
// - any rod stop blocks manual and auto withdrawal
// - rod stop setpoint kept below trip setpoint
// - temperature control uses second highest loop
// - temperature deviation alarm above threshold
// - two of four dT flags: block, runback
// - dT limits as percent of nominal dT
// - control selection never alters the vote
// - test-tripped channel counts as tripped
package pvl_pkg;
   localparam int NCH   = 4;
   localparam int VAL_W = 16;
   // register byte addresses
   localparam logic [7:0] ADR_CTRL     = 8'h00;
   localparam logic [7:0] ADR_BYP      = 8'h04;
   localparam logic [7:0] ADR_TEST     = 8'h08;
   localparam logic [7:0] ADR_FLX_HI   = 8'h0C;
   localparam logic [7:0] ADR_FLX_LO   = 8'h10;
   localparam logic [7:0] ADR_ROD      = 8'h14;
   localparam logic [7:0] ADR_FDEV     = 8'h18;
   localparam logic [7:0] ADR_TDEV     = 8'h1C;
   localparam logic [7:0] ADR_DTPCT    = 8'h20;
   localparam logic [7:0] ADR_STAT     = 8'h24;
   localparam logic [7:0] ADR_FSEL     = 8'h28;
   localparam logic [7:0] ADR_TSEL     = 8'h2C;
   localparam logic [7:0] ADR_DTNOM    = 8'h40;
   localparam logic [7:0] ADR_NOM_MASK = 8'hF0;
   // status field positions
   localparam int ST_TRIP  = 0;
   localparam int ST_RODB  = 1;
   localparam int ST_RUNB  = 2;
   localparam int ST_FDEV  = 3;
   localparam int ST_TDEV  = 4;
   localparam int ST_BYPI  = 5;
   localparam int ST_CAUSE = 8;
   localparam int ST_BYPA  = 12;
   // reset values
   localparam logic [15:0] RST_FLX_HI = 16'hE000;
   localparam logic [15:0] RST_FLX_LO = 16'h4000;
   localparam logic [15:0] RST_ROD    = 16'hD000;
   localparam logic [15:0] RST_DEV    = 16'h0800;
   localparam logic [15:0] RST_DTPCT  = 16'h0064;
   localparam logic [15:0] RST_DTNOM  = 16'h1000;
   localparam logic [31:0] PCT_FULL   = 32'h0000_0064;
endpackage : pvl_pkg

//--- tb/pvl_chan_model.sv
/*
 pvl_chan_model: behavioural channel values, switches and trip breaker
 facing the voter. Assumes the bench calls its tasks just after a rising edge.
*/
`timescale 1ns/10ps
module pvl_chan_model
   import pvl_pkg::*;
(
   // clock and trip demand
   input  wire logic                      clk_i,
   input  wire logic                      reactor_trip_i,
   // channel values and switches
   output      logic [NCH-1:0][VAL_W-1:0] flux_o,
   output      logic [NCH-1:0][VAL_W-1:0] tavg_o,
   output      logic [NCH-1:0][VAL_W-1:0] dt_o,
   output      logic                      permissive_o,
   output      logic                      manual_trip_o,
   output      logic                      op_reset_o,
   // breaker state
   output      logic                      breaker_open_o
);
   ////////////////////////////////////////////////////////////////////////
   // balanced plant at time zero, so no flag is set out of reset
   initial begin
      flux_o = {NCH{16'h2000}};
      tavg_o = {NCH{16'h2000}};
      dt_o = {NCH{16'h0100}};
      {permissive_o, manual_trip_o, op_reset_o, breaker_open_o} = 4'h0;
   end
   // breaker opens on demand and stays open; nothing in the bench recloses it
   always @(posedge clk_i) begin
      if (reactor_trip_i === 1'b1) begin
         breaker_open_o <= 1'b1;
      end
   end
   // kind 0 flux, 1 loop average, 2 loop dT; channel 0 is the first value
   task automatic set4(input int k, input logic [VAL_W-1:0] a, b, c, d);
      case (k)
         0: flux_o <= {d, c, b, a};
         1: tavg_o <= {d, c, b, a};
         default: dt_o <= {d, c, b, a};
      endcase
   endtask : set4
   task automatic sw(input logic p, m, r);
      {permissive_o, manual_trip_o, op_reset_o} <= {p, m, r};
   endtask : sw
endmodule : pvl_chan_model

//--- tb/tb_pvl_voter.sv
/*
 tb_pvl_voter: self-checking bench for the voter through its bus and pins.
 Assumes one-cycle bus ack and three-edge input-to-output delay.
*/
`timescale 1ns/10ps
module tb_pvl_voter;
   import pvl_pkg::*;
   logic                      clk_i = 1'b0;
   logic                      rst_i = 1'b1;
   logic                      cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
   logic [7:0]                adr_i = 8'h00;
   logic [3:0]                sel_i = 4'h0;
   logic [31:0]               dat_i = 32'h0, dat_o, q;
   logic                      ack_o, permissive_i, manual_trip_i, op_reset_i, brk;
   logic [NCH-1:0][VAL_W-1:0] flux_i, tavg_i, dt_i;
   logic                      reactor_trip_o, trip_alarm_o, trip_annunc_o, visual_alarm_o;
   logic                      audible_alarm_o, rod_block_man_o, rod_block_auto_o;
   logic                      turbine_runback_o, flux_dev_alarm_o, temp_dev_alarm_o;
   logic                      bypass_ind_o;
   logic [NCH-1:0]            first_cause_o;
   logic [VAL_W-1:0]          flux_ctl_o, tavg_ctl_o;
   int                        n_errors = 0, tests_run = 0;
   ////////////////////////////////////////////////////////////////////////
   // 20 MHz clock
   always #25 clk_i = ~clk_i;
   pvl_voter dut_u (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o,
      .ack_o, .flux_i, .tavg_i, .dt_i, .permissive_i, .manual_trip_i, .op_reset_i,
      .reactor_trip_o, .trip_alarm_o, .trip_annunc_o, .first_cause_o, .visual_alarm_o,
      .audible_alarm_o, .rod_block_man_o, .rod_block_auto_o, .turbine_runback_o,
      .flux_dev_alarm_o, .temp_dev_alarm_o, .bypass_ind_o, .flux_ctl_o, .tavg_ctl_o);
   pvl_chan_model chan_u (.clk_i, .reactor_trip_i(reactor_trip_o), .flux_o(flux_i),
      .tavg_o(tavg_i), .dt_o(dt_i), .permissive_o(permissive_i),
      .manual_trip_o(manual_trip_i), .op_reset_o(op_reset_i), .breaker_open_o(brk));
   ////////////////////////////////////////////////////////////////////////
   // shared tasks
   task automatic tally_and_finish;
      $display("checks %0d, errors %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : tally_and_finish
   task automatic check(input logic ok, input string msg);
      tests_run++;
      if (ok !== 1'b1) begin
         n_errors++;
         $display("ERROR at %0t: %s", $time, msg);
      end
   endtask : check
   // classic cycle: request held until ack is sampled, then released
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_i);
      {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} <= {2'b11, w, a, 4'hF, d};
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 20);
      q = dat_o;
      {cyc_i, stb_i, we_i} <= 3'b000;
      if (ack_o !== 1'b1) begin
         check(1'b0, "bus ack timeout");
         tally_and_finish();
      end
   endtask : wb
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input string msg);
      wb(1'b0, a, 32'h0);
      check(q === e, msg);
   endtask : rd
   // three edges of sync and output register plus margin
   task automatic settle;
      repeat (5) @(posedge clk_i);
      #1;
   endtask : settle
   task automatic plant(input int k, input logic [VAL_W-1:0] a, b, c, d);
      @(posedge clk_i);
      chan_u.set4(k, a, b, c, d);
      settle();
   endtask : plant
   task automatic sw(input logic p, m, r);
      @(posedge clk_i);
      chan_u.sw(p, m, r);
      settle();
   endtask : sw
   task automatic op_reset(input logic p);
      sw(p, 1'b0, 1'b1);
      sw(p, 1'b0, 1'b0);
   endtask : op_reset
   ////////////////////////////////////////////////////////////////////////
   // scenarios
   task automatic t_reset;
      check({reactor_trip_o, visual_alarm_o, turbine_runback_o} === 3'b000, "out rst");
      rd(ADR_FLX_HI, 32'h0000E000, "trip sp rst");
      rd(ADR_ROD, 32'h0000D000, "rod sp rst");
      rd(ADR_DTPCT, 32'h00000064, "pct rst");
      rd(ADR_DTNOM, 32'h00001000, "nom rst");
      rd(ADR_STAT, 32'h00000000, "status rst");
      rd(8'h30, 32'h00000000, "unmapped read");
   endtask : t_reset
   task automatic t_overpower;
      plant(0, 16'hD800, 16'h2000, 16'h2000, 16'h2000);
      check({rod_block_man_o, rod_block_auto_o} === 2'b11, "rod block");
      check({visual_alarm_o, audible_alarm_o} === 2'b11, "rod stop alarm");
      check(reactor_trip_o === 1'b0, "trip below sp");
      plant(0, 16'hD800, 16'hE000, 16'hE000, 16'h2000);
      check(reactor_trip_o === 1'b1 && brk === 1'b1, "2of4 trip");
      check({trip_alarm_o, trip_annunc_o} === 2'b11, "trip alarm");
      check(first_cause_o === 4'h6, "first cause");
      plant(0, 16'h2000, 16'h2000, 16'h2000, 16'h2000);
      check(reactor_trip_o === 1'b1 && first_cause_o === 4'h6, "latch held");
      op_reset(1'b0);
      check(reactor_trip_o === 1'b0 && first_cause_o === 4'h0, "op reset");
   endtask : t_overpower
   task automatic t_select;
      plant(0, 16'h3000, 16'h3100, 16'h3200, 16'h9000);
      plant(1, 16'h2000, 16'h2100, 16'h2050, 16'h2080);
      check(flux_ctl_o === 16'h3200 && flux_dev_alarm_o === 1'b1, "flux sel hi");
      check(tavg_ctl_o === 16'h2080 && temp_dev_alarm_o === 1'b0, "tavg sel");
      check(reactor_trip_o === 1'b0, "ctl no trip");
      rd(ADR_FSEL, 32'h00003200, "fsel reg");
      // a wider threshold must swallow the same 5E00 spread
      wb(1'b1, ADR_FDEV, 32'h6000);
      settle();
      check(flux_dev_alarm_o === 1'b0, "fdev sp");
      plant(0, 16'h3000, 16'h3100, 16'h3200, 16'h3300);
      plant(1, 16'h2000, 16'h2100, 16'h6000, 16'h2080);
      check(flux_ctl_o === 16'h3200 && flux_dev_alarm_o === 1'b0, "flux no dev");
      check(tavg_ctl_o === 16'h2100 && temp_dev_alarm_o === 1'b1, "tavg dev");
      plant(1, 16'h2000, 16'h2000, 16'h2000, 16'h2000);
   endtask : t_select
   task automatic t_tight;
      plant(0, 16'h5000, 16'h5000, 16'h2000, 16'h2000);
      check(reactor_trip_o === 1'b0, "loose sp");
      wb(1'b1, ADR_CTRL, 32'h1);
      settle();
      check(reactor_trip_o === 1'b1 && first_cause_o === 4'h3, "tight sp");
      check(rod_block_man_o === 1'b1, "rod sp below tight");
      plant(0, 16'h2000, 16'h2000, 16'h2000, 16'h2000);
      wb(1'b1, ADR_CTRL, 32'h0);
      op_reset(1'b0);
      check(reactor_trip_o === 1'b0, "tight clear");
   endtask : t_tight
   task automatic t_bypass;
      sw(1'b1, 1'b0, 1'b0);
      wb(1'b1, ADR_BYP, 32'h1);
      settle();
      check(bypass_ind_o === 1'b1, "bypass ind");
      plant(0, 16'hE000, 16'hE000, 16'h2000, 16'h2000);
      check(reactor_trip_o === 1'b0, "bypassed vote");
      sw(1'b0, 1'b0, 1'b0);
      check(bypass_ind_o === 1'b0, "bypass removed");
      check(reactor_trip_o === 1'b1 && first_cause_o === 4'h3, "vote restored");
      rd(ADR_BYP, 32'h0, "byp cleared");
      wb(1'b1, ADR_BYP, 32'h2);
      rd(ADR_BYP, 32'h0, "byp refused");
      plant(0, 16'h2000, 16'h2000, 16'h2000, 16'h2000);
      op_reset(1'b0);
   endtask : t_bypass
   task automatic t_test;
      wb(1'b1, ADR_TEST, 32'h1);
      settle();
      check(bypass_ind_o === 1'b1 && visual_alarm_o === 1'b1, "test ind");
      check(reactor_trip_o === 1'b0, "one tested");
      plant(0, 16'h2000, 16'hE000, 16'h2000, 16'h2000);
      check(reactor_trip_o === 1'b1 && first_cause_o === 4'h3, "1of3");
      wb(1'b1, ADR_TEST, 32'h0);
      plant(0, 16'h2000, 16'h2000, 16'h2000, 16'h2000);
      op_reset(1'b0);
      check(reactor_trip_o === 1'b0, "test clear");
   endtask : t_test
   task automatic t_manual;
      @(posedge clk_i);
      chan_u.sw(1'b0, 1'b1, 1'b0);
      repeat (3) @(posedge clk_i);
      #1;
      check(reactor_trip_o === 1'b1 && first_cause_o === 4'h0, "manual trip");
      check({trip_alarm_o, trip_annunc_o} === 2'b11, "manual alarm");
      sw(1'b0, 1'b0, 1'b0);
      check(reactor_trip_o === 1'b1, "manual held");
      op_reset(1'b0);
      check(reactor_trip_o === 1'b0, "manual clear");
   endtask : t_manual
   task automatic t_dt;
      plant(2, 16'h1000, 16'h0100, 16'h0100, 16'h0100);
      check({rod_block_auto_o, turbine_runback_o} === 2'b00, "dt 1of4");
      plant(2, 16'h1000, 16'h1000, 16'h0100, 16'h0100);
      check({rod_block_auto_o, turbine_runback_o} === 2'b11, "dt 2of4");
      check({reactor_trip_o, rod_block_man_o} === 2'b00, "dt no trip");
      wb(1'b1, ADR_DTNOM, 32'h2000);
      settle();
      check(turbine_runback_o === 1'b0, "nominal scaled");
      wb(1'b1, ADR_DTPCT, 32'h32);
      settle();
      check(turbine_runback_o === 1'b1, "percent scaled");
      plant(2, 16'h0100, 16'h0100, 16'h0100, 16'h0100);
   endtask : t_dt
   ////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      settle();
      t_reset();
      t_overpower();
      t_select();
      t_tight();
      t_bypass();
      t_test();
      t_manual();
      t_dt();
      tally_and_finish();
   end
endmodule : tb_pvl_voter
